// File: tpu_consts.vh
`ifndef TPU_CONSTS_VH
`define TPU_CONSTS_VH

// Register offsets
`define TPU_OFF_CTRL    8'h00
`define TPU_OFF_MADDR   8'h04
`define TPU_OFF_WDATA   8'h08
`define TPU_OFF_RDATA   8'h0C
`define TPU_OFF_TBASE   8'h10
`define TPU_OFF_LAT     8'h14
`define TPU_OFF_CMDST   8'h18
`define TPU_OFF_ISR     8'h1C
`define TPU_OFF_IMASK   8'h20
`define TPU_OFF_SCRATCH 8'h24

// Control register fields
`define TPU_CTRL_START  0
`define TPU_CTRL_WRITE  1
`define TPU_CTRL_CNT_LO 4
`define TPU_CTRL_CNT_HI 7
`define TPU_CTRL_BUSY   8
`define TPU_CTRL_PARK   9

// Configuration command/status flag positions
`define TPU_CMDST_DPE   31
`define TPU_CMDST_MABT  29
`define TPU_CMDST_TABT  28

// Interrupt status flag positions
`define TPU_ISR_DONE    0
`define TPU_ISR_ABN     15

// Reset values
`define TPU_LAT_RST     8'h10
`define TPU_TBASE_RST   32'h0000_1000

// Bus commands
`define TPU_CMD_IORD    4'h2
`define TPU_CMD_IOWR    4'h3
`define TPU_CMD_MRD     4'h6
`define TPU_CMD_MWR     4'h7

// Clocks a master waits for a target to claim the cycle
`define TPU_DEVSEL_WAIT 3'h5
// Data phases taken back on disconnect and on retry
`define TPU_BACK_DISC   2'h1
`define TPU_BACK_RETRY  2'h2

`endif

// File: tpu_parity.v
`timescale 1ns/1ps
`include "tpu_consts.vh"

module tpu_parity (
    input wire mclk_i,          // Bus clock
    input wire [31:0] ad_i,     // Address/data as seen on the bus
    input wire [3:0] cbe_n_i,   // Command/byte enables as seen on the bus
    input wire par_i,           // Parity as seen on the bus
    input wire [31:0] ad_drv_i, // Address/data this agent drives
    input wire [3:0] cbe_drv_i, // Command/byte enables this agent drives
    output reg par_q,           // Generated parity, one clock late
    output wire err_o           // Parity of the previous phase mismatches
);

    reg [31:0] ad_r;
    reg [3:0] cbe_r;

    // ------------------------------------------------------------
    // Even parity over 36 lines
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        ad_r <= ad_i;
        cbe_r <= cbe_n_i;
        par_q <= ^{ad_drv_i, cbe_drv_i};
    end

    // Valid in the clock where the parity for ad_r is on the bus
    assign err_o = ^{ad_r, cbe_r, par_i};

endmodule

// File: tpu_core.v
`timescale 1ns/1ps
`include "tpu_consts.vh"

// Function
// - Target burst access: assert stop to make the host end it.
// - Target stop stays asserted until the initiator releases frame.
// - As target, never signal target abort.
// - Initiator ends with frame high, irdy low; idle when both high.
// - Grant gone and latency expired: end normally within one more phase.
// - No devsel within five clocks: master abort, set bits 29 and 15.
// - Stop with devsel deasserted: release bus, set bits 28 and 15.
// - Disconnect: release bus, later retry at least the last transfer.
// - Retry without trdy: release bus, later repeat the last two transfers.
// - Generate and check even parity over ad and cbe.
// - Driven ad and cbe lines always carry defined levels.
// - Master parity error or perr seen: set bits 31 and 15.
// - Parity follows its address or data phase by one clock.
// - Target address parity error: serr pulse one clock, one after parity.
// - Target write or master read data error: perr one after parity.
// - Granted while the bus is idle: park on the bus.
module tpu_core (
    input wire mclk_i,          // Bus clock, 200 MHz
    input wire reset_i,         // Synchronous reset, active high
    input wire [7:0] addr_i,    // Register address
    input wire [31:0] wdata_i,  // Register write data
    input wire wr_i,            // Register write strobe
    input wire rd_i,            // Register read strobe
    output reg [31:0] rdata_o,  // Register read data, cycle after read
    output reg irq_o,           // Interrupt, level, active high
    input wire [31:0] ad_i,     // Bus address/data in
    output reg [31:0] ad_o,     // Bus address/data out
    output reg ad_oe_o,         // Bus address/data enable
    input wire [3:0] cbe_n_i,   // Command/byte enables in
    output reg [3:0] cbe_n_o,   // Command/byte enables out
    output reg cbe_oe_o,        // Command/byte enables enable
    input wire par_i,           // Parity in
    output wire par_o,          // Parity out
    output reg par_oe_o,        // Parity enable
    input wire frame_n_i,       // Frame in
    output reg frame_n_o,       // Frame out
    output reg frame_oe_o,      // Frame enable
    input wire irdy_n_i,        // Initiator ready in
    output reg irdy_n_o,        // Initiator ready out
    output reg irdy_oe_o,       // Initiator ready enable
    input wire trdy_n_i,        // Target ready in
    output reg trdy_n_o,        // Target ready out
    output reg trdy_oe_o,       // Target ready enable
    input wire stop_n_i,        // Stop in
    output reg stop_n_o,        // Stop out
    output reg stop_oe_o,       // Stop enable
    input wire devsel_n_i,      // Device select in
    output reg devsel_n_o,      // Device select out
    output reg devsel_oe_o,     // Device select enable
    input wire perr_n_i,        // Data parity error in
    output reg perr_n_o,        // Data parity error out
    output reg perr_oe_o,       // Data parity error enable
    output reg serr_n_o,        // System error out, open drain
    output reg serr_oe_o,       // System error enable
    input wire gnt_n_i,         // Grant from arbiter
    output reg req_n_o          // Request to arbiter
);

    localparam [4:0] M_IDLE = 5'h01;
    localparam [4:0] M_REQ = 5'h02;
    localparam [4:0] M_ADDR = 5'h04;
    localparam [4:0] M_DATA = 5'h08;
    localparam [4:0] M_TURN = 5'h10;
    localparam [4:0] T_IDLE = 5'h01;
    localparam [4:0] T_WAIT = 5'h02;
    localparam [4:0] T_XFER = 5'h04;
    localparam [4:0] T_STOP = 5'h08;
    localparam [4:0] T_TURN = 5'h10;

    reg [4:0] mst_q;
    reg [4:0] tgt_q;
    reg busy_q;
    reg mwr_q;
    reg [3:0] cnt_q;
    reg [4:0] idx_q;
    reg [31:0] maddr_q;
    reg [31:0] wdat_q;
    reg [31:0] rdat_q;
    reg [31:0] tbase_q;
    reg [7:0] lat_lim_q;
    reg [7:0] lat_q;
    reg [2:0] wait_q;
    reg dsel_seen_q;
    reg quit_q;
    reg parked_q;
    reg [31:0] scratch_q;
    reg twr_q;
    reg frame_prev_q;
    reg achk_q;
    reg dchk_q;
    reg mchk_q;
    reg ev_ma_q;
    reg ev_ta_q;
    reg ev_pe_q;
    reg ev_done_q;
    reg cf_dpe_q;
    reg cf_mabt_q;
    reg cf_tabt_q;
    reg isr_done_q;
    reg isr_abn_q;
    reg imask_done_q;
    reg imask_abn_q;
    wire par_err;
    wire mst_act;
    wire xfer;
    wire lat_out;
    wire [4:0] cnt_w;

    function [4:0] back_off;
        input [4:0] n;
        input [1:0] b;
        begin
            back_off = (n > {3'h0, b}) ? n - {3'h0, b} : 5'h00;
        end
    endfunction

    function hit;
        input [31:0] a;
        input [3:0] c;
        input [31:0] base;
        begin
            hit = (a[31:4] == base[31:4]) &&
                  (c == `TPU_CMD_IORD || c == `TPU_CMD_IOWR ||
                   c == `TPU_CMD_MRD || c == `TPU_CMD_MWR);
        end
    endfunction

    tpu_parity u_par (
        .mclk_i(mclk_i),
        .ad_i(ad_i),
        .cbe_n_i(cbe_n_i),
        .par_i(par_i),
        .ad_drv_i(ad_o),
        .cbe_drv_i(cbe_n_o),
        .par_q(par_o),
        .err_o(par_err)
    );

    assign mst_act = (mst_q == M_ADDR) | (mst_q == M_DATA) | (mst_q == M_TURN);
    assign xfer = ~irdy_n_o & ~trdy_n_i & ~devsel_n_i;
    assign lat_out = (lat_q >= lat_lim_q) & gnt_n_i;
    assign cnt_w = {1'b0, cnt_q};

    // ------------------------------------------------------------
    // Bus state machines
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        ev_ma_q <= 1'b0;
        ev_ta_q <= 1'b0;
        ev_done_q <= 1'b0;
        frame_prev_q <= frame_n_i;
        // parity enable follows the data it covers by one clock
        par_oe_o <= ad_oe_o;
        if (reset_i)
        begin
            mst_q <= M_IDLE;
            tgt_q <= T_IDLE;
            busy_q <= 1'b0;
            idx_q <= 5'h00;
            lat_q <= 8'h00;
            wait_q <= 3'h0;
            dsel_seen_q <= 1'b0;
            quit_q <= 1'b0;
            parked_q <= 1'b0;
            twr_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            scratch_q <= 32'h0000_0000;
            ad_o <= 32'h0000_0000;
            ad_oe_o <= 1'b0;
            cbe_n_o <= 4'h0;
            cbe_oe_o <= 1'b0;
            par_oe_o <= 1'b0;
            {frame_n_o, irdy_n_o, trdy_n_o, stop_n_o, devsel_n_o} <= 5'h1F;
            {frame_oe_o, irdy_oe_o, trdy_oe_o, stop_oe_o, devsel_oe_o} <= 5'h00;
            req_n_o <= 1'b1;
        end
        else
        begin
            if (wr_i && addr_i == `TPU_OFF_CTRL && wdata_i[`TPU_CTRL_START] &&
                !busy_q && wdata_i[`TPU_CTRL_CNT_HI:`TPU_CTRL_CNT_LO] != 4'h0)
            begin
                busy_q <= 1'b1;
                idx_q <= 5'h00;
            end
            if (wr_i && addr_i == `TPU_OFF_SCRATCH)
                scratch_q <= wdata_i;
            case (mst_q)
            M_IDLE:
            begin
                // park when granted on an idle bus
                if (!gnt_n_i && frame_n_i && irdy_n_i && tgt_q == T_IDLE)
                begin
                    parked_q <= 1'b1;
                    ad_o <= 32'h0000_0000;
                    cbe_n_o <= 4'h0;
                    ad_oe_o <= 1'b1;
                    cbe_oe_o <= 1'b1;
                end
                else if (tgt_q == T_IDLE)
                begin
                    parked_q <= 1'b0;
                    ad_oe_o <= 1'b0;
                    cbe_oe_o <= 1'b0;
                end
                if (busy_q && idx_q < cnt_w && tgt_q == T_IDLE)
                begin
                    req_n_o <= 1'b0;
                    mst_q <= M_REQ;
                end
            end
            M_REQ:
            begin
                if (!gnt_n_i && frame_n_i && irdy_n_i && tgt_q == T_IDLE)
                begin
                    // address and command driven at full levels
                    ad_o <= maddr_q + {25'h0, idx_q, 2'b00};
                    cbe_n_o <= mwr_q ? `TPU_CMD_MWR : `TPU_CMD_MRD;
                    ad_oe_o <= 1'b1;
                    cbe_oe_o <= 1'b1;
                    frame_n_o <= 1'b0;
                    frame_oe_o <= 1'b1;
                    irdy_oe_o <= 1'b1;
                    req_n_o <= 1'b1;
                    parked_q <= 1'b0;
                    lat_q <= 8'h00;
                    wait_q <= 3'h0;
                    dsel_seen_q <= 1'b0;
                    quit_q <= 1'b0;
                    mst_q <= M_ADDR;
                end
            end
            M_ADDR:
            begin
                irdy_n_o <= 1'b0;
                cbe_n_o <= 4'h0;
                ad_oe_o <= mwr_q;
                ad_o <= mwr_q ? wdat_q + {27'h0, idx_q} : 32'h0000_0000;
                // single remaining word: final phase at once
                if (idx_q + 5'h01 == cnt_w)
                    frame_n_o <= 1'b1;
                wait_q <= 3'h1;
                lat_q <= lat_q + 8'h01;
                mst_q <= M_DATA;
            end
            M_DATA:
            begin
                if (lat_q != 8'hFF)
                    lat_q <= lat_q + 8'h01;
                if (!devsel_n_i)
                    dsel_seen_q <= 1'b1;
                if (wait_q != `TPU_DEVSEL_WAIT)
                    wait_q <= wait_q + 3'h1;
                if (quit_q)
                begin
                    // irdy released one clock after frame
                    irdy_n_o <= 1'b1;
                    mst_q <= M_TURN;
                end
                else if (devsel_n_i && !dsel_seen_q && wait_q == `TPU_DEVSEL_WAIT)
                begin
                    ev_ma_q <= 1'b1;
                    busy_q <= 1'b0;
                    frame_n_o <= 1'b1;
                    quit_q <= ~frame_n_o;
                    irdy_n_o <= frame_n_o;
                    if (frame_n_o)
                        mst_q <= M_TURN;
                end
                else if (!stop_n_i && devsel_n_i && dsel_seen_q)
                begin
                    ev_ta_q <= 1'b1;
                    busy_q <= 1'b0;
                    frame_n_o <= 1'b1;
                    quit_q <= ~frame_n_o;
                    irdy_n_o <= frame_n_o;
                    if (frame_n_o)
                        mst_q <= M_TURN;
                end
                else if (!stop_n_i && !devsel_n_i)
                begin
                    // disconnect backs off one, retry two
                    idx_q <= back_off(idx_q + {4'h0, xfer},
                                      trdy_n_i ? `TPU_BACK_RETRY : `TPU_BACK_DISC);
                    frame_n_o <= 1'b1;
                    quit_q <= ~frame_n_o;
                    irdy_n_o <= frame_n_o;
                    if (frame_n_o)
                        mst_q <= M_TURN;
                end
                else if (xfer)
                begin
                    idx_q <= idx_q + 5'h01;
                    if (mwr_q)
                        ad_o <= wdat_q + {27'h0, idx_q} + 32'h0000_0001;
                    else
                        rdat_q <= ad_i;
                    // last transfer done, bus goes idle
                    if (frame_n_o)
                    begin
                        irdy_n_o <= 1'b1;
                        mst_q <= M_TURN;
                    end
                    // time-out allows at most one more phase here
                    else if (idx_q + 5'h02 == cnt_w || lat_out)
                        frame_n_o <= 1'b1;
                end
                // time-out while waiting on the target
                else if (lat_out && !frame_n_o)
                    frame_n_o <= 1'b1;
            end
            M_TURN:
            begin
                ad_oe_o <= 1'b0;
                cbe_oe_o <= 1'b0;
                frame_oe_o <= 1'b0;
                irdy_oe_o <= 1'b0;
                if (busy_q && idx_q == cnt_w)
                begin
                    busy_q <= 1'b0;
                    ev_done_q <= 1'b1;
                end
                mst_q <= M_IDLE;
            end
            default:
                mst_q <= M_IDLE;
            endcase

            case (tgt_q)
            T_IDLE:
            begin
                if (!frame_n_i && frame_prev_q && !mst_act &&
                    hit(ad_i, cbe_n_i, tbase_q))
                begin
                    twr_q <= cbe_n_i[0];
                    devsel_n_o <= 1'b0;
                    {devsel_oe_o, trdy_oe_o, stop_oe_o} <= 3'h7;
                    if (mst_q == M_REQ)
                    begin
                        req_n_o <= 1'b1;
                        mst_q <= M_IDLE;
                    end
                    tgt_q <= T_WAIT;
                end
            end
            T_WAIT:
            begin
                trdy_n_o <= 1'b0;
                // burst seen: disconnect with the first data
                if (!frame_n_i)
                    stop_n_o <= 1'b0;
                if (!twr_q)
                begin
                    // Byte enables are not honoured on reads
                    ad_o <= scratch_q;
                    ad_oe_o <= 1'b1;
                end
                tgt_q <= T_XFER;
            end
            T_XFER:
            begin
                if (!irdy_n_i)
                begin
                    if (twr_q && cbe_n_i != 4'hF)
                        scratch_q <= ad_i;
                    trdy_n_o <= 1'b1;
                    ad_oe_o <= 1'b0;
                    if (frame_n_i)
                    begin
                        devsel_n_o <= 1'b1;
                        stop_n_o <= 1'b1;
                        tgt_q <= T_TURN;
                    end
                    else
                    begin
                        stop_n_o <= 1'b0;
                        tgt_q <= T_STOP;
                    end
                end
            end
            T_STOP:
            begin
                // hold stop until frame goes away
                // devsel stays low, so this is never an abort
                if (frame_n_i)
                begin
                    devsel_n_o <= 1'b1;
                    stop_n_o <= 1'b1;
                    tgt_q <= T_TURN;
                end
            end
            T_TURN:
            begin
                {devsel_oe_o, trdy_oe_o, stop_oe_o} <= 3'h0;
                tgt_q <= T_IDLE;
            end
            default:
                tgt_q <= T_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Parity checking
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            achk_q <= 1'b0;
            dchk_q <= 1'b0;
            mchk_q <= 1'b0;
            ev_pe_q <= 1'b0;
            perr_n_o <= 1'b1;
            perr_oe_o <= 1'b0;
            serr_n_o <= 1'b0;
            serr_oe_o <= 1'b0;
        end
        else
        begin
            achk_q <= !frame_n_i && frame_prev_q && !mst_act;
            dchk_q <= (tgt_q == T_XFER && twr_q && !irdy_n_i) ||
                      (mst_q == M_DATA && !mwr_q && xfer);
            mchk_q <= mst_q == M_DATA && !mwr_q && xfer;
            serr_oe_o <= achk_q & par_err;
            serr_n_o <= 1'b0;
            // perr after the data parity; drive high one clock to release
            perr_n_o <= ~(dchk_q & par_err);
            perr_oe_o <= (dchk_q & par_err) | ~perr_n_o;
            // master sees its own error or another agent's perr
            ev_pe_q <= (mchk_q & par_err) | (mst_act & ~perr_n_i);
        end
    end

    // ------------------------------------------------------------
    // Register file and interrupt
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            mwr_q <= 1'b0;
            cnt_q <= 4'h0;
            maddr_q <= 32'h0000_0000;
            wdat_q <= 32'h0000_0000;
            tbase_q <= `TPU_TBASE_RST;
            lat_lim_q <= `TPU_LAT_RST;
            cf_dpe_q <= 1'b0;
            cf_mabt_q <= 1'b0;
            cf_tabt_q <= 1'b0;
            isr_done_q <= 1'b0;
            isr_abn_q <= 1'b0;
            imask_done_q <= 1'b0;
            imask_abn_q <= 1'b0;
            rdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end
        else
        begin
            if (wr_i)
            begin
                case (addr_i)
                `TPU_OFF_CTRL:
                begin
                    if (!busy_q)
                    begin
                        mwr_q <= wdata_i[`TPU_CTRL_WRITE];
                        cnt_q <= wdata_i[`TPU_CTRL_CNT_HI:`TPU_CTRL_CNT_LO];
                    end
                end
                `TPU_OFF_MADDR: maddr_q <= {wdata_i[31:2], 2'b00};
                `TPU_OFF_WDATA: wdat_q <= wdata_i;
                `TPU_OFF_TBASE: tbase_q <= wdata_i;
                `TPU_OFF_LAT: lat_lim_q <= wdata_i[7:0];
                `TPU_OFF_IMASK:
                begin
                    imask_done_q <= wdata_i[`TPU_ISR_DONE];
                    imask_abn_q <= wdata_i[`TPU_ISR_ABN];
                end
                default: ;
                endcase
            end
            // Read clears the status; a same-cycle event still sets it
            // flags and abnormal summary
            cf_dpe_q <= ev_pe_q | (cf_dpe_q & ~(rd_i && addr_i == `TPU_OFF_CMDST));
            cf_mabt_q <= ev_ma_q | (cf_mabt_q & ~(rd_i && addr_i == `TPU_OFF_CMDST));
            cf_tabt_q <= ev_ta_q | (cf_tabt_q & ~(rd_i && addr_i == `TPU_OFF_CMDST));
            isr_abn_q <= ev_pe_q | ev_ma_q | ev_ta_q |
                         (isr_abn_q & ~(rd_i && addr_i == `TPU_OFF_ISR));
            isr_done_q <= ev_done_q | (isr_done_q & ~(rd_i && addr_i == `TPU_OFF_ISR));
            irq_o <= (isr_done_q & imask_done_q) | (isr_abn_q & imask_abn_q);
            rdata_o <= 32'h0000_0000;
            if (rd_i)
            begin
                case (addr_i)
                `TPU_OFF_CTRL:
                    rdata_o <= {22'h0, parked_q, busy_q, cnt_q, 2'b00, mwr_q, 1'b0};
                `TPU_OFF_MADDR: rdata_o <= maddr_q;
                `TPU_OFF_WDATA: rdata_o <= wdat_q;
                `TPU_OFF_RDATA: rdata_o <= rdat_q;
                `TPU_OFF_TBASE: rdata_o <= tbase_q;
                `TPU_OFF_LAT: rdata_o <= {24'h0, lat_lim_q};
                `TPU_OFF_CMDST: rdata_o <= {cf_dpe_q, 1'b0, cf_mabt_q, cf_tabt_q, 28'h0};
                `TPU_OFF_ISR: rdata_o <= {16'h0, isr_abn_q, 14'h0, isr_done_q};
                `TPU_OFF_IMASK: rdata_o <= {16'h0, imask_abn_q, 14'h0, imask_done_q};
                `TPU_OFF_SCRATCH: rdata_o <= scratch_q;
                default: rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// File: tpu_core_properties.sv
`timescale 1ns/1ps
module tpu_core_props (
    input wire mclk_i, reset_i, frame_n_i, irdy_n_i, devsel_n_i, gnt_n_i, req_n_o, // Bus
    input wire [31:0] ad_o, // Data out
    input wire [3:0] cbe_n_o, // Enables out
    input wire ad_oe_o, cbe_oe_o, par_o, par_oe_o, frame_n_o, frame_oe_o, irdy_n_o, // Out
    input wire irdy_oe_o, trdy_n_o, trdy_oe_o, stop_n_o, stop_oe_o, devsel_n_o, // Out
    input wire devsel_oe_o, serr_oe_o // Out
);
default clocking @(posedge mclk_i); endclocking
default disable iff (reset_i);
// Own cycle opened, then nobody claims it
sequence s_start; frame_oe_o && $fell(frame_n_o); endsequence
sequence s_quiet; devsel_n_i [*6]; endsequence
a_burst_stop: assert property ($fell(trdy_n_o) && trdy_oe_o && !frame_n_i |-> !stop_n_o)
    else $error("no stop");
a_stop_held: assert property (stop_oe_o && !stop_n_o && !frame_n_i |=> !stop_n_o)
    else $error("stop early");
a_no_tabort: assert property (stop_oe_o && !stop_n_o |-> devsel_oe_o && !devsel_n_o)
    else $error("target abort");
a_final_irdy: assert property (frame_oe_o && $rose(frame_n_o) |-> irdy_oe_o && !irdy_n_o)
    else $error("bad final");
a_mabort_exit: assert property (s_start ##1 s_quiet |-> ##[0:3] (frame_n_o && irdy_n_o))
    else $error("no abort");
a_par_follows: assert property ($past(ad_oe_o) |-> par_oe_o &&
    par_o == ^{$past(ad_o), $past(cbe_n_o)}) else $error("bad parity");
a_serr_pulse: assert property ($rose(serr_oe_o) |=> !serr_oe_o) else $error("serr long");
a_park_drive: assert property ((frame_n_i && irdy_n_i && !gnt_n_i && req_n_o) [*3]
    |-> ad_oe_o && cbe_oe_o && ad_o == 32'h0 && cbe_n_o == 4'h0) else $error("not parked");
endmodule

// File: tpu_bus_model.sv
`timescale 1ns/1ps
module tpu_bus_model (
    input wire mclk_i, reset_i, frame_n_i, irdy_n_i, req_n_i, // Bus in
    input wire [1:0] mode_i, // 0 normal, 1 silent, 2 abort, 3 park
    output reg gnt_n_o, devsel_n_o, trdy_n_o, stop_n_o // High when released
);
reg act_q;
always @(posedge mclk_i)
begin
    gnt_n_o <= reset_i | (req_n_i & (mode_i != 2'h3));
    if (reset_i || (frame_n_i && irdy_n_i))
        {act_q, devsel_n_o, trdy_n_o, stop_n_o} <= 4'h7;
    else if (!frame_n_i && !gnt_n_o && !act_q && mode_i != 2'h1)
        {act_q, devsel_n_o} <= 2'h2;
    else if (act_q && mode_i == 2'h2)
        {devsel_n_o, stop_n_o} <= 2'h2;
    // Ready one cycle behind irdy, a slow target
    else if (act_q)
        trdy_n_o <= irdy_n_i;
end
endmodule

// File: tpu_tb.sv
`timescale 1ns/1ps
`include "tpu_consts.vh"
module testbench;
reg mclk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, h_fr = 1'b1, h_ir = 1'b1;
reg h_par = 1'b0;
reg [7:0] addr_i = 8'h0;
reg [31:0] wdata_i = 32'h0, h_ad = 32'h0, lf = 32'h63, v;
reg [3:0] h_cbe = 4'hF;
reg [1:0] mode = 2'h0;
integer failures = 0, n_compared = 0, serr_cnt = 0, i, j;
reg [31:0] q[$];
wire [31:0] rdata_o, ad_o;
wire [3:0] cbe_n_o;
wire irq_o, ad_oe_o, cbe_oe_o, par_o, par_oe_o, frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o;
wire trdy_n_o, trdy_oe_o, stop_n_o, stop_oe_o, devsel_n_o, devsel_oe_o, perr_n_o, perr_oe_o;
wire serr_n_o, serr_oe_o, req_n_o, gnt_n_i, m_dev, m_trdy, m_stop;
// ----
// Bus wires
// ----
wire [31:0] ad_i = ad_oe_o ? ad_o : h_ad;
wire [3:0] cbe_n_i = cbe_oe_o ? cbe_n_o : h_cbe;
wire par_i = par_oe_o ? par_o : h_par;
wire frame_n_i = frame_oe_o ? frame_n_o : h_fr;
wire irdy_n_i = irdy_oe_o ? irdy_n_o : h_ir;
wire trdy_n_i = trdy_oe_o ? trdy_n_o : m_trdy;
wire stop_n_i = stop_oe_o ? stop_n_o : m_stop;
wire devsel_n_i = devsel_oe_o ? devsel_n_o : m_dev;
wire perr_n_i = perr_oe_o ? perr_n_o : 1'b1;
tpu_core dut_u (.*);
tpu_bus_model mdl_u (.mclk_i, .reset_i, .frame_n_i, .irdy_n_i, .req_n_i(req_n_o), .mode_i(mode),
    .gnt_n_o(gnt_n_i), .devsel_n_o(m_dev), .trdy_n_o(m_trdy), .stop_n_o(m_stop));
initial forever #2.5 mclk_i = ~mclk_i;
always @(posedge mclk_i)
begin
    if (irdy_oe_o && !irdy_n_i && !trdy_n_i)
        q.push_back(ad_i);
    if (serr_oe_o)
        serr_cnt = serr_cnt + 1;
end
function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task final_report;
    if (failures == 0 && n_compared > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task chk(input [31:0] s, input [31:0] e);
    n_compared = n_compared + 1;
    if (s !== e)
    begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
endtask
task wr(input [7:0] a, input [31:0] d);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
endtask
task rd(input [7:0] a);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
endtask
// Flags trail the bus by two cycles, irq by three
task run(input [1:0] m, input [3:0] n);
    mode <= m;
    lf = nx(lf);
    wr(`TPU_OFF_MADDR, {lf[31:2], 2'h0});
    wr(`TPU_OFF_WDATA, lf);
    wr(`TPU_OFF_CTRL, {24'h0, n, 4'h3});
    rd(`TPU_OFF_CTRL);
    for (i = 0; i < 80 && v[8] !== 1'b0; i = i + 1)
        rd(`TPU_OFF_CTRL);
    if (v[8] !== 1'b0)
    begin
        failures = failures + 1;
        final_report;
    end
    repeat (3) @(posedge mclk_i);
    #1;
endtask
initial
begin
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd(`TPU_OFF_LAT);
    chk(v, 32'h10);
    wr(`TPU_OFF_IMASK, 32'h8000);
    run(2'h0, 4'h3);
    chk(q.size(), 3);
    for (j = 0; j < 3; j = j + 1)
        chk(q[j], lf + j);
    chk(irq_o, 1'b0);
    rd(`TPU_OFF_ISR);
    chk(v, 32'h1);
    wr(`TPU_OFF_LAT, 32'h2);
    run(2'h0, 4'h4);
    chk(q.size(), 7);
    for (j = 3; j < 7; j = j + 1)
        chk(q[j], lf + j - 3);
    for (j = 1; j < 3; j = j + 1)
    begin
        run(j[1:0], 4'h1);
        chk(irq_o, 1'b1);
        rd(`TPU_OFF_CMDST);
        chk(v, (j == 1) ? 32'h2000_0000 : 32'h1000_0000);
        rd(`TPU_OFF_ISR);
        chk(v & 32'h8000, 32'h8000);
        @(posedge mclk_i);
        #1 chk(irq_o, 1'b0);
    end
    lf = nx(lf);
    {h_fr, h_ad, h_cbe} <= {1'b0, `TPU_TBASE_RST, `TPU_CMD_MWR};
    @(posedge mclk_i);
    {h_ir, h_ad, h_cbe, h_par} <= {1'b0, lf, 4'h0, ~^{`TPU_TBASE_RST, `TPU_CMD_MWR}};
    @(posedge mclk_i);
    h_par <= ^lf;
    #1;
    for (i = 0; i < 9 && stop_n_i !== 1'b0; i = i + 1)
        #5;
    chk(stop_n_i, 1'b0);
    h_fr <= 1'b1;
    @(posedge mclk_i);
    {h_ir, h_cbe, h_ad} <= {1'b1, 4'hF, ~lf};
    repeat (2) @(posedge mclk_i);
    #1 rd(`TPU_OFF_SCRATCH);
    chk(v, lf);
    chk(serr_cnt, 1);
    mode <= 2'h3;
    repeat (6) @(posedge mclk_i);
    #1 chk(ad_i, 32'h0);
    rd(`TPU_OFF_CTRL);
    chk(v[9], 1'b1);
    final_report;
end
initial
begin
    #300000;
    failures = failures + 1;
    final_report;
end
endmodule
bind tpu_core tpu_core_props chk_u (.*);
